// [core/rhp_top.sv]
// hardware-mode pin control: straps, muxes, status pins
`timescale 1ns/10ps
module rhp_top import rhp_pkg::*; (
    // clocks and reset
    input wire logic SYS_CLK_I,
    input wire logic RESETN_I,
    input wire logic REC_MCLK_I,
    input wire logic SYSTEM_CLOCK_IN_I,
    // clock recovery
    input wire logic PLL_LOCK_I,
    output logic REC_MCLK_O,
    output logic MCLK_SRC_SYS_O,
    output logic MCLK_RATIO_128_O,
    // line input muxes
    input wire logic [3:0] LINE_IN_I,
    input wire logic [1:0] RX_SEL_I,
    input wire logic [1:0] PASS_SEL_I,
    output logic RX_DATA_O,
    // decoder status, system clock domain
    input wire logic NONVALID_ERR_I,
    input wire logic RECEIVE_ERR_I,
    input wire logic PCM_VALID_I,
    input wire logic [11:0] RATE_100HZ_I,
    // decoder frame data, recovered clock domain
    input wire logic FRAME_STB_I,
    input wire logic Z_PREAMBLE_I,
    input wire logic CS_BIT_I,
    input wire logic USER_BIT_I,
    input wire logic SER_DATA_I,
    // serial audio out pin
    input wire logic SER_OUT_I,
    output logic SER_OUT_O,
    output logic SER_OUT_OE_N_O,
    // passthrough pin
    input wire logic PASS_OUT_I,
    output logic PASS_OUT_O,
    output logic PASS_OUT_OE_N_O,
    // error pin
    input wire logic ERR_I,
    output logic ERR_O,
    output logic ERR_OE_N_O,
    // audio flag pin
    input wire logic AUDIO_I,
    output logic AUDIO_O,
    output logic AUDIO_OE_N_O,
    // high rate flag pin
    input wire logic HIGH_RATE_I,
    output logic HIGH_RATE_O,
    output logic HIGH_RATE_OE_N_O,
    // block start pin
    input wire logic BLOCK_START_I,
    output logic BLOCK_START_O,
    output logic BLOCK_START_OE_N_O,
    // status bit pin
    input wire logic STATUS_BIT_I,
    output logic STATUS_BIT_O,
    output logic STATUS_BIT_OE_N_O,
    // side bit pin
    input wire logic SIDE_BIT_I,
    output logic SIDE_BIT_O,
    output logic SIDE_BIT_OE_N_O,
    // word rate clock pin
    input wire logic WORD_CLK_I,
    output logic WORD_CLK_O,
    output logic WORD_CLK_OE_N_O,
    // configuration taken from straps, strap done flag, and low power flag taken from reset
    output logic HW_MODE_O,
    output logic PHASE_DET_SEL_O,
    output logic [1:0] FMT_SEL_O,
    output logic SP_MASTER_O,
    output logic EMPH_MATCH_O,
    output logic STRAP_DONE_O,
    output logic LOW_POWER_O
);
    rhp_link_if lk();

    logic [NSTRAP-1:0] pin_in, pin_s1_r, pin_s2_r, strap_r;
    logic [2:0] wait_r;
    logic strap_done_r, drv_n, take;
    logic sck_s1_r, sck_s2_r, sck_s3_r, ext_mode_r;
    logic lock_s1_r, lock_s2_r, mclk_sys_r;
    logic [1:0] rxs_s1_r, rxs_s2_r, pss_s1_r, pss_s2_r;
    logic err_r, audio_r, hr_r, err_nxt;

    assign LOW_POWER_O = ~RESETN_I;

    // strap pins, gathered in strap order
    always_comb begin
        pin_in = STRAP_RST;
        pin_in[STB_SER] = SER_OUT_I;
        pin_in[STB_PASS] = PASS_OUT_I;
        pin_in[STB_ERR] = ERR_I;
        pin_in[STB_AUDIO] = AUDIO_I;
        pin_in[STB_RATE] = HIGH_RATE_I;
        pin_in[STB_BLK] = BLOCK_START_I;
        pin_in[STB_CS] = STATUS_BIT_I;
        pin_in[STB_USER] = SIDE_BIT_I;
    end

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            pin_s1_r <= STRAP_RST;
            pin_s2_r <= STRAP_RST;
        end else begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
        end
    end

    // wait until the synchroniser holds post-release levels
    assign take = !strap_done_r && (wait_r == STRAP_WAIT_CNT);

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            wait_r <= 3'h0;
            strap_done_r <= 1'b0;
        end else if (take) begin
            strap_done_r <= 1'b1;
        end else if (!strap_done_r) begin
            wait_r <= wait_r + 3'h1;
        end
    end

    // straps frozen once taken; only a new reset reopens them
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            strap_r <= STRAP_RST;
        end else if (take) begin
            strap_r <= pin_s2_r;
        end
    end

    assign STRAP_DONE_O = strap_done_r;
    assign HW_MODE_O = strap_done_r & ~strap_r[STB_SER];
    assign PHASE_DET_SEL_O = strap_r[STB_PASS];
    assign FMT_SEL_O = {strap_r[STB_AUDIO], strap_r[STB_CS]};
    assign EMPH_MATCH_O = strap_r[STB_RATE];
    assign SP_MASTER_O = strap_r[STB_BLK];
    assign MCLK_RATIO_128_O = strap_r[STB_USER];

    // pins stay released until their strap levels are taken
    assign drv_n = ~strap_done_r;
    assign SER_OUT_OE_N_O = drv_n;
    assign PASS_OUT_OE_N_O = drv_n;
    assign ERR_OE_N_O = drv_n;
    assign AUDIO_OE_N_O = drv_n;
    assign HIGH_RATE_OE_N_O = drv_n;
    assign BLOCK_START_OE_N_O = drv_n;
    assign STATUS_BIT_OE_N_O = drv_n;
    assign SIDE_BIT_OE_N_O = drv_n;
    assign WORD_CLK_OE_N_O = drv_n | ~strap_r[STB_BLK];

    // system clock pin sampled as a level; it must run well
    // below half the system clock for an edge to be seen
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            lock_s1_r <= 1'b0;
            lock_s2_r <= 1'b0;
        end else begin
            sck_s1_r <= SYSTEM_CLOCK_IN_I;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            lock_s1_r <= PLL_LOCK_I;
            lock_s2_r <= lock_s1_r;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ext_mode_r <= 1'b0;
        end else if (strap_done_r && sck_s2_r && !sck_s3_r) begin
            ext_mode_r <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mclk_sys_r <= 1'b0;
        end else begin
            mclk_sys_r <= ext_mode_r & ~lock_s2_r;
        end
    end

    assign MCLK_SRC_SYS_O = mclk_sys_r;
    // plain clock mux: a switch may leave one runt pulse
    assign REC_MCLK_O = mclk_sys_r ? SYSTEM_CLOCK_IN_I : REC_MCLK_I;

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rxs_s1_r <= 2'h0;
            rxs_s2_r <= 2'h0;
            pss_s1_r <= 2'h0;
            pss_s2_r <= 2'h0;
        end else begin
            rxs_s1_r <= RX_SEL_I;
            rxs_s2_r <= rxs_s1_r;
            pss_s1_r <= PASS_SEL_I;
            pss_s2_r <= pss_s1_r;
        end
    end

    // the line signals are not retimed: a flop here would add jitter
    assign RX_DATA_O = LINE_IN_I[rxs_s2_r];
    assign PASS_OUT_O = LINE_IN_I[pss_s2_r];

    assign err_nxt = strap_r[STB_ERR] ? RECEIVE_ERR_I
                                      : (NONVALID_ERR_I | RECEIVE_ERR_I);

    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            err_r <= 1'b0;
            audio_r <= 1'b0;
        end else if (strap_done_r) begin
            err_r <= err_nxt;
            audio_r <= ~PCM_VALID_I;
        end
    end

    // between the two limits the flag simply keeps its last value
    always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            hr_r <= 1'b0;
        end else if (strap_done_r) begin
            if (RATE_100HZ_I <= FS_LOW_LIMIT) begin
                hr_r <= 1'b0;
            end else if (RATE_100HZ_I >= FS_HIGH_LIMIT) begin
                hr_r <= 1'b1;
            end
        end
    end

    assign ERR_O = err_r;
    assign AUDIO_O = audio_r;
    assign HIGH_RATE_O = hr_r;

    // recovered clock side
    assign lk.rstn = RESETN_I;
    assign lk.cfg[CFG_DONE] = strap_done_r;
    assign lk.cfg[CFG_MASTER] = strap_r[STB_BLK];
    assign lk.cfg[CFG_RATIO] = strap_r[STB_USER];
    assign lk.frame_stb = FRAME_STB_I;
    assign lk.z_pre = Z_PREAMBLE_I;
    assign lk.cs_bit = CS_BIT_I;
    assign lk.user_bit = USER_BIT_I;
    assign lk.ser_data = SER_DATA_I;
    assign lk.word_in = WORD_CLK_I;

    rhp_link u_link (
        .rec_mclk_i(REC_MCLK_I),
        .lk(lk.link)
    );

    assign BLOCK_START_O = lk.blk;
    assign STATUS_BIT_O = lk.cs_out;
    assign SIDE_BIT_O = lk.user_out;
    assign WORD_CLK_O = lk.word_out;
    assign SER_OUT_O = lk.ser_out;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESETN_I);

    property p_ext_rise;
        $rose(ext_mode_r) |-> $past(strap_done_r && sck_s2_r && !sck_s3_r);
    endproperty
    a_ext_rise: assert property (p_ext_rise) else $error("mode no edge");
    property p_ext_hold;
        ext_mode_r |=> ext_mode_r;
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("mode dropped");
    property p_route;
        ext_mode_r && !lock_s2_r |=> MCLK_SRC_SYS_O;
    endproperty
    a_route: assert property (p_route) else $error("no reroute");
    property p_no_route;
        !ext_mode_r || lock_s2_r |=> !MCLK_SRC_SYS_O;
    endproperty
    a_no_route: assert property (p_no_route) else $error("bad reroute");
    property p_release;
        !strap_done_r |-> SER_OUT_OE_N_O && PASS_OUT_OE_N_O && ERR_OE_N_O
            && AUDIO_OE_N_O && HIGH_RATE_OE_N_O && BLOCK_START_OE_N_O
            && STATUS_BIT_OE_N_O && SIDE_BIT_OE_N_O && WORD_CLK_OE_N_O;
    endproperty
    a_release: assert property (p_release) else $error("early drive");
    property p_strap_hold;
        strap_done_r |=> strap_done_r && $stable(strap_r);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap moved");
    property p_hw_mode;
        $rose(strap_done_r) |-> HW_MODE_O == !$past(pin_s2_r[STB_SER]);
    endproperty
    a_hw_mode: assert property (p_hw_mode) else $error("bad mode");
    property p_rx_mux;
        $stable(RX_SEL_I) [*3] |-> RX_DATA_O == LINE_IN_I[RX_SEL_I];
    endproperty
    a_rx_mux: assert property (p_rx_mux) else $error("rx mux");
    property p_pass_mux;
        $stable(PASS_SEL_I) [*3] |-> PASS_OUT_O == LINE_IN_I[PASS_SEL_I];
    endproperty
    a_pass_mux: assert property (p_pass_mux) else $error("pass mux");
    property p_err;
        strap_done_r && !strap_r[STB_ERR] && NONVALID_ERR_I |=> ERR_O;
    endproperty
    a_err: assert property (p_err) else $error("error lost");
    property p_err_rx;
        strap_r[STB_ERR] && !RECEIVE_ERR_I |=> !ERR_O;
    endproperty
    a_err_rx: assert property (p_err_rx) else $error("error leak");
    property p_audio;
        strap_done_r |=> AUDIO_O == !$past(PCM_VALID_I);
    endproperty
    a_audio: assert property (p_audio) else $error("audio flag");
    property p_rate;
        strap_done_r && RATE_100HZ_I <= FS_LOW_LIMIT |=> !HIGH_RATE_O;
    endproperty
    a_rate: assert property (p_rate) else $error("rate flag");
    property p_rate_hi;
        strap_done_r && RATE_100HZ_I >= FS_HIGH_LIMIT |=> HIGH_RATE_O;
    endproperty
    a_rate_hi: assert property (p_rate_hi) else $error("rate high");
    c_ext: cover property ($rose(ext_mode_r));
    c_src: cover property ($rose(MCLK_SRC_SYS_O));
    c_done: cover property ($rose(strap_done_r) && HW_MODE_O);
    c_hr: cover property ($rose(HIGH_RATE_O));
endmodule // rhp_top

// [core/rhp_pkg.sv]
// constants shared by the hardware-mode pin control block
package rhp_pkg;
    // strap pin positions in the sampled strap vector
    localparam int STB_SER = 0;
    localparam int STB_PASS = 1;
    localparam int STB_ERR = 2;
    localparam int STB_AUDIO = 3;
    localparam int STB_RATE = 4;
    localparam int STB_BLK = 5;
    localparam int STB_CS = 6;
    localparam int STB_USER = 7;
    localparam int NSTRAP = 8;
    localparam logic [7:0] STRAP_RST = 8'h00;
    // cycles after reset release before straps are taken
    localparam logic [2:0] STRAP_WAIT_CNT = 3'h3;
    // sample rate limits in units of 100 Hz (48.0 kHz, 88.1 kHz)
    localparam logic [11:0] FS_LOW_LIMIT = 12'h1e0;
    localparam logic [11:0] FS_HIGH_LIMIT = 12'h371;
    // frame counts within a status block
    localparam logic [7:0] BLK_RISE = 8'h02;
    localparam logic [7:0] BLK_FALL = 8'h12;
    localparam logic [7:0] BLK_MAX = 8'hff;
    // recovered clock cycles per word clock half period, minus one
    localparam logic [6:0] WHALF_256 = 7'h7f;
    localparam logic [6:0] WHALF_128 = 7'h3f;
    // link side configuration bit positions
    localparam int CFG_RATIO = 0;
    localparam int CFG_MASTER = 1;
    localparam int CFG_DONE = 2;
endpackage

// [core/rhp_link_if.sv]
// carrier between the system side and the recovered clock side
`timescale 1ns/10ps
interface rhp_link_if;
    // system side levels
    logic rstn;
    logic [2:0] cfg;
    // recovered clock domain inputs
    logic frame_stb;
    logic z_pre;
    logic cs_bit;
    logic user_bit;
    logic ser_data;
    logic word_in;
    // recovered clock domain outputs
    logic blk;
    logic cs_out;
    logic user_out;
    logic word_out;
    logic ser_out;
    modport ctl (
        output rstn, cfg, frame_stb, z_pre, cs_bit, user_bit,
        output ser_data, word_in,
        input blk, cs_out, user_out, word_out, ser_out
    );
    modport link (
        input rstn, cfg, frame_stb, z_pre, cs_bit, user_bit,
        input ser_data, word_in,
        output blk, cs_out, user_out, word_out, ser_out
    );
endinterface

// [core/rhp_link.sv]
// recovered clock side: block start, status and side bits, word clock
`timescale 1ns/10ps
module rhp_link import rhp_pkg::*; (
    // recovered master clock
    input wire logic rec_mclk_i,
    // carrier
    rhp_link_if.link lk
);
    logic rst_s1_r, rstn_r;
    logic [2:0] cfg_s1_r, cfg_r;
    logic win_s1_r, win_s2_r, wprev_r, wgen_r, wnow;
    logic [6:0] wdiv_r, whalf;
    logic [7:0] frm_r, frm_nxt;
    logic blk_r, c_r, u_r, ser_r, run_m;

    // release of reset is retimed into this domain
    always_ff @(posedge rec_mclk_i or negedge lk.rstn) begin
        if (!lk.rstn) begin
            rst_s1_r <= 1'b0;
            rstn_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rstn_r <= rst_s1_r;
        end
    end

    always_ff @(posedge rec_mclk_i or negedge rstn_r) begin
        if (!rstn_r) begin
            cfg_s1_r <= 3'h0;
            cfg_r <= 3'h0;
            win_s1_r <= 1'b0;
            win_s2_r <= 1'b0;
        end else begin
            cfg_s1_r <= lk.cfg;
            cfg_r <= cfg_s1_r;
            win_s1_r <= lk.word_in;
            win_s2_r <= win_s1_r;
        end
    end

    assign run_m = cfg_r[CFG_DONE] & cfg_r[CFG_MASTER];
    assign whalf = cfg_r[CFG_RATIO] ? WHALF_128 : WHALF_256;

    // master: word clock divided from the recovered clock
    always_ff @(posedge rec_mclk_i or negedge rstn_r) begin
        if (!rstn_r) begin
            wdiv_r <= 7'h00;
            wgen_r <= 1'b0;
        end else if (run_m) begin
            if (wdiv_r == whalf) begin
                wdiv_r <= 7'h00;
                wgen_r <= ~wgen_r;
            end else begin
                wdiv_r <= wdiv_r + 7'h01;
            end
        end
    end

    assign wnow = run_m ? wgen_r : win_s2_r;

    always_ff @(posedge rec_mclk_i or negedge rstn_r) begin
        if (!rstn_r) begin
            wprev_r <= 1'b0;
            c_r <= 1'b0;
            u_r <= 1'b0;
        end else begin
            wprev_r <= wnow;
            if (wnow != wprev_r) begin
                c_r <= lk.cs_bit;
                u_r <= lk.user_bit;
            end
        end
    end

    always_comb begin
        frm_nxt = frm_r;
        if (lk.frame_stb) begin
            if (lk.z_pre) begin
                frm_nxt = 8'h00;
            end else if (frm_r != BLK_MAX) begin
                frm_nxt = frm_r + 8'h01;
            end
        end
    end

    // counter parks at max until the first block start is seen
    always_ff @(posedge rec_mclk_i or negedge rstn_r) begin
        if (!rstn_r) begin
            frm_r <= BLK_MAX;
            blk_r <= 1'b0;
            ser_r <= 1'b0;
        end else begin
            frm_r <= frm_nxt;
            blk_r <= (frm_nxt >= BLK_RISE) && (frm_nxt < BLK_FALL);
            ser_r <= lk.ser_data;
        end
    end

    assign lk.blk = blk_r;
    assign lk.cs_out = c_r;
    assign lk.user_out = u_r;
    assign lk.word_out = wgen_r;
    assign lk.ser_out = ser_r;

    property p_blk_rise;
        @(posedge rec_mclk_i) disable iff (!rstn_r)
        $rose(blk_r) |-> frm_r == BLK_RISE;
    endproperty
    a_blk_rise: assert property (p_blk_rise) else $error("late rise");
    property p_blk_fall;
        @(posedge rec_mclk_i) disable iff (!rstn_r)
        $fell(blk_r) |-> frm_r == BLK_FALL || frm_r == 8'h00;
    endproperty
    a_blk_fall: assert property (p_blk_fall) else $error("bad fall");
    property p_cs;
        @(posedge rec_mclk_i) disable iff (!rstn_r)
        wnow != wprev_r |=> c_r == $past(lk.cs_bit) && u_r == $past(lk.user_bit);
    endproperty
    a_cs: assert property (p_cs) else $error("bit not taken");
    property p_word;
        @(posedge rec_mclk_i) disable iff (!rstn_r)
        run_m && wdiv_r == whalf |=> wgen_r != $past(wgen_r);
    endproperty
    a_word: assert property (p_word) else $error("no toggle");
    c_blk: cover property (@(posedge rec_mclk_i) disable iff (!rstn_r)
        $fell(blk_r));
endmodule // rhp_link

// [dv/rhp_proc_model.sv]
// downstream audio processor model: word clock source in slave role
`timescale 1ns/10ps
module rhp_proc_model #(
    parameter int HALF = 8
) (
    // clock and reset
    input wire logic bclk_i,
    input wire logic rstn_i,
    // role and data
    input wire logic run_i,
    input wire logic ser_i,
    // word clock pin
    output logic word_o,
    output logic word_oe_n_o
);
    int cnt;
    logic ser_r;
    // word clock stands still unless this side owns it
    assign word_oe_n_o = !run_i;
    always @(posedge bclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 0;
            word_o <= 1'b0;
        end else if (run_i) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                word_o <= !word_o;
            end
        end
    end
    // audio words are taken but not judged here
    always @(posedge bclk_i) begin
        ser_r <= ser_i;
    end
endmodule // rhp_proc_model

// [dv/rhp_top_tb.sv]
// self-checking bench for the hardware-mode pin control block
`timescale 1ns/10ps
module rhp_top_tb;
    import rhp_pkg::*;
    logic clk = 0, rclk = 0, rstn = 0, oclk = 0, oen = 0, lock = 1;
    logic [3:0] line = 0;
    logic [1:0] rsel = 0, psel = 0;
    logic nv = 0, re = 0, pcm = 0, fstb = 0, z = 0, cs = 0, ub = 0;
    logic sd = 0, run = 0, pm_w, pm_oe_n, rmo, src, r128, rxd;
    logic hw, pds, spm, emph, done, lowp;
    logic [1:0] fmt;
    logic [11:0] rate = 0;
    logic [7:0] st = 0;
    wire [8:0] po, poe, pin;
    logic [11:0] rt [6] = '{FS_LOW_LIMIT, FS_HIGH_LIMIT, 12'h258,
                           FS_LOW_LIMIT, 12'h258, 12'h064};
    localparam logic [5:0] REXP = 6'h06;
    int n_fail = 0, checked = 0;

    always #10 clk = ~clk;
    initial begin
        #4;
        forever #15 rclk = ~rclk;
    end
    // one driver only: the clock parks low whenever it is disabled
    always #25 oclk = oen ? ~oclk : 1'b0;
    // released strap pins rest at their pull level
    assign pin[7:0] = (poe[7:0] & st) | (~poe[7:0] & po[7:0]);
    assign pin[8] = !poe[8] ? po[8] : (!pm_oe_n ? pm_w : ~po[8]);

    rhp_top DUT (
        .SYS_CLK_I(clk), .RESETN_I(rstn), .REC_MCLK_I(rclk),
        .SYSTEM_CLOCK_IN_I(oclk), .PLL_LOCK_I(lock), .REC_MCLK_O(rmo),
        .MCLK_SRC_SYS_O(src), .MCLK_RATIO_128_O(r128), .LINE_IN_I(line),
        .RX_SEL_I(rsel), .PASS_SEL_I(psel), .RX_DATA_O(rxd),
        .NONVALID_ERR_I(nv), .RECEIVE_ERR_I(re), .PCM_VALID_I(pcm),
        .RATE_100HZ_I(rate), .FRAME_STB_I(fstb), .Z_PREAMBLE_I(z),
        .CS_BIT_I(cs), .USER_BIT_I(ub), .SER_DATA_I(sd),
        .SER_OUT_I(pin[0]), .SER_OUT_O(po[0]), .SER_OUT_OE_N_O(poe[0]),
        .PASS_OUT_I(pin[1]), .PASS_OUT_O(po[1]), .PASS_OUT_OE_N_O(poe[1]),
        .ERR_I(pin[2]), .ERR_O(po[2]), .ERR_OE_N_O(poe[2]),
        .AUDIO_I(pin[3]), .AUDIO_O(po[3]), .AUDIO_OE_N_O(poe[3]),
        .HIGH_RATE_I(pin[4]), .HIGH_RATE_O(po[4]),
        .HIGH_RATE_OE_N_O(poe[4]), .BLOCK_START_I(pin[5]),
        .BLOCK_START_O(po[5]), .BLOCK_START_OE_N_O(poe[5]),
        .STATUS_BIT_I(pin[6]), .STATUS_BIT_O(po[6]),
        .STATUS_BIT_OE_N_O(poe[6]), .SIDE_BIT_I(pin[7]),
        .SIDE_BIT_O(po[7]), .SIDE_BIT_OE_N_O(poe[7]),
        .WORD_CLK_I(pin[8]), .WORD_CLK_O(po[8]), .WORD_CLK_OE_N_O(poe[8]),
        .HW_MODE_O(hw), .PHASE_DET_SEL_O(pds), .FMT_SEL_O(fmt),
        .SP_MASTER_O(spm), .EMPH_MATCH_O(emph), .STRAP_DONE_O(done),
        .LOW_POWER_O(lowp)
    );
    rhp_proc_model #(.HALF(8)) u_proc (
        .bclk_i(rclk), .rstn_i(rstn), .run_i(run), .ser_i(po[0]),
        .word_o(pm_w), .word_oe_n_o(pm_oe_n)
    );

    task end_sim;
        $display("checks %0d fails %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [11:0] g, input logic [11:0] e, input string m);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task sc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task rc(input int n);
        repeat (n) @(negedge rclk);
    endtask
    task cfg_chk(input logic [7:0] s);
        chk(hw, !s[STB_SER], "hw mode");
        chk(pds, s[STB_PASS], "phase det");
        chk(fmt, {s[STB_AUDIO], s[STB_CS]}, "format");
        chk(spm, s[STB_BLK], "port role");
        chk(emph, s[STB_RATE], "emphasis");
        chk(r128, s[STB_USER], "ratio");
    endtask
    task start(input logic [7:0] s);
        int i;
        sc(1);
        rstn = 0;
        oen = 0;
        st = s;
        run = !s[STB_BLK];
        sc(12);
        chk(lowp, 1'b1, "low power");
        chk(poe, 9'h1ff, "enables in reset");
        chk(done, 1'b0, "done in reset");
        rstn = 1;
        i = 0;
        while (done !== 1'b1) begin
            sc(1);
            i++;
            if (i > 20) begin
                n_fail++;
                end_sim();
            end
        end
        sc(6);
        cfg_chk(s);
        chk(poe, {!s[STB_BLK], 8'h00}, "pin drive");
        // straps must be ignored once taken
        st = ~s;
        sc(6);
        cfg_chk(s);
    endtask
    task word_chk(input int half);
        int n;
        logic w;
        for (int j = 0; j < 2; j++) begin
            n = 0;
            w = pin[8];
            while (pin[8] === w && n < 300) begin
                rc(1);
                n++;
            end
        end
        chk(n, half, "word half period");
    endtask
    task common(input logic [7:0] s);
        for (int k = 0; k < 8; k++) begin
            line = (4'h1 << k[1:0]) ^ {4{k[2]}};
            rsel = k[1:0];
            psel = ~k[1:0];
            sc(4);
            chk(rxd, !k[2], "rx mux");
            chk(po[1], k[2], "pass mux");
        end
        psel = ~rsel;
        for (int k = 0; k < 4; k++) begin
            {nv, re} = k[1:0];
            pcm = k[0];
            sc(3);
            chk(po[2], s[STB_ERR] ? re : nv | re, "err");
            chk(po[3], !pcm, "audio");
        end
        for (int k = 0; k < 2; k++) begin
            rc(1);
            cs = k[0];
            ub = !k[0];
            sd = !k[0];
            rc(150);
            chk(po[0], sd, "ser out");
            chk(po[6], cs, "status bit");
            chk(po[7], ub, "side bit");
        end
    endtask

    initial begin
        start(8'h0a);
        chk(src, 1'b0, "locked source");
        for (int k = 0; k < 6; k++) begin
            rate = rt[k];
            sc(3);
            chk(po[4], REXP[k], "high rate");
        end
        rc(2);
        chk(po[5], 1'b0, "blk before z");
        for (int k = 0; k < 21; k++) begin
            fstb = 1;
            z = (k == 0);
            rc(1);
            fstb = 0;
            z = 0;
            chk(po[5], k >= 2 && k < 18, "blk");
            rc(3);
        end
        common(8'h0a);
        sc(1);
        oen = 1;
        lock = 0;
        sc(12);
        chk(src, 1'b1, "sys clock routed");
        @(posedge oclk);
        #1;
        chk(rmo, 1'b1, "clock out high");
        @(negedge oclk);
        #1;
        chk(rmo, 1'b0, "clock out low");
        sc(1);
        lock = 1;
        sc(6);
        chk(src, 1'b0, "relock source");
        start(8'hf5);
        lock = 0;
        sc(12);
        chk(src, 1'b0, "no sys clock edge");
        word_chk(int'(WHALF_128) + 1);
        common(8'hf5);
        end_sim();
    end
endmodule // rhp_top_tb
